// ==== core/boundary_scan_defines.svh ====
/*
 * Fixed figures of the boundary-scan port: register widths, chain ends,
 * instruction codes, capture constants and identification field positions.
 * Assumes it is included by bare name from core/ sources and from the bench.
 */
`ifndef BOUNDARY_SCAN_DEFINES_SVH
`define BOUNDARY_SCAN_DEFINES_SVH

// Instruction register
`define IR_WIDTH        5
`define IR_CAPTURE_VAL  5'h01
`define INSTR_EXTEST    5'h00
`define INSTR_SAMPLE    5'h01
`define INSTR_IDREAD    5'h02
`define INSTR_FLOAT     5'h03
`define INSTR_BYPASS    5'h1f

// Boundary chain
`define BSR_LEN         281
`define BSR_TOP         280
`define BSR_RESERVED    0

// Identification register layout
`define ID_WIDTH        32
`define ID_VER_HI       31
`define ID_VER_LO       28
`define ID_PART_HI      27
`define ID_PART_LO      12
`define ID_MAKER_HI     11
`define ID_MAKER_LO     1
`define ID_LSB_VAL      1'h1

`endif

// ==== core/boundary_scan_pkg.sv ====
/*
 * Types of the boundary-scan port: controller states, register selection
 * and the state records of the controller and the data path.
 * Assumes boundary_scan_defines.svh is on the include path.
 */
`include "boundary_scan_defines.svh"
`default_nettype none
package boundary_scan_pkg;

    // Sixteen controller states, one-hot
    typedef enum logic [15:0] {
        st_reset    = 16'h0001,
        st_idle     = 16'h0002,
        st_sel_dr   = 16'h0004,
        st_cap_dr   = 16'h0008,
        st_shift_dr = 16'h0010,
        st_exit1_dr = 16'h0020,
        st_pause_dr = 16'h0040,
        st_exit2_dr = 16'h0080,
        st_upd_dr   = 16'h0100,
        st_sel_ir   = 16'h0200,
        st_cap_ir   = 16'h0400,
        st_shift_ir = 16'h0800,
        st_exit1_ir = 16'h1000,
        st_pause_ir = 16'h2000,
        st_exit2_ir = 16'h4000,
        st_upd_ir   = 16'h8000
    } tap_state_t;

    // Data register placed between data in and data out
    typedef enum logic [2:0] {
        sel_chain  = 3'h1,
        sel_ident  = 3'h2,
        sel_bypass = 3'h4
    } reg_sel_t;

    typedef struct packed {
        tap_state_t st;
    } fsm_q_t;

    // Everything clocked on the rising test clock in the data path
    typedef struct packed {
        logic [`IR_WIDTH-1:0] ir_shift;
        logic [`IR_WIDTH-1:0] ir_out;
        logic [`BSR_LEN-1:0]  bsr_shift;
        logic [`BSR_LEN-1:0]  bsr_out;
        logic [`ID_WIDTH-1:0] id_shift;
        logic                 bypass;
    } scan_q_t;

    // Falling-edge output stage
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } out_q_t;

endpackage
`default_nettype wire

// ==== core/scan_sync.sv ====
/*
 * Two-flop level synchroniser of parameterised width.
 * Assumes d comes from another clock domain or a pin and is quasi-static.
 */
`default_nettype none
module scan_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock and synchronous clear
    input  wire logic             clk,
    input  wire logic             clear,
    // Level in and out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (clear) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule
`default_nettype wire

// ==== core/tap_fsm.sv ====
/*
 * Sixteen-state test controller, advanced by mode select on the rising
 * test clock. Assumes tms is stable around that edge and force_reset is
 * already synchronous to tck.
 */
`default_nettype none
module tap_fsm (
    // Test clock and asynchronous test reset
    input  wire logic                         tck,
    input  wire logic                         trst_n,
    // Controls
    input  wire logic                         tms,
    input  wire logic                         force_reset,
    // Current state
    output boundary_scan_pkg::tap_state_t     state
);
    boundary_scan_pkg::fsm_q_t q, d;

    // Next state from mode select sampled on the rising edge
    always_comb begin
        d = q;
        if (force_reset) begin
            d.st = boundary_scan_pkg::st_reset;
        end else begin
            case (q.st)
                boundary_scan_pkg::st_reset:    d.st = tms ? boundary_scan_pkg::st_reset
                                                           : boundary_scan_pkg::st_idle;
                boundary_scan_pkg::st_idle:     d.st = tms ? boundary_scan_pkg::st_sel_dr
                                                           : boundary_scan_pkg::st_idle;
                boundary_scan_pkg::st_sel_dr:   d.st = tms ? boundary_scan_pkg::st_sel_ir
                                                           : boundary_scan_pkg::st_cap_dr;
                boundary_scan_pkg::st_cap_dr:   d.st = tms ? boundary_scan_pkg::st_exit1_dr
                                                           : boundary_scan_pkg::st_shift_dr;
                boundary_scan_pkg::st_shift_dr: d.st = tms ? boundary_scan_pkg::st_exit1_dr
                                                           : boundary_scan_pkg::st_shift_dr;
                boundary_scan_pkg::st_exit1_dr: d.st = tms ? boundary_scan_pkg::st_upd_dr
                                                           : boundary_scan_pkg::st_pause_dr;
                boundary_scan_pkg::st_pause_dr: d.st = tms ? boundary_scan_pkg::st_exit2_dr
                                                           : boundary_scan_pkg::st_pause_dr;
                boundary_scan_pkg::st_exit2_dr: d.st = tms ? boundary_scan_pkg::st_upd_dr
                                                           : boundary_scan_pkg::st_shift_dr;
                boundary_scan_pkg::st_upd_dr:   d.st = tms ? boundary_scan_pkg::st_sel_dr
                                                           : boundary_scan_pkg::st_idle;
                boundary_scan_pkg::st_sel_ir:   d.st = tms ? boundary_scan_pkg::st_reset
                                                           : boundary_scan_pkg::st_cap_ir;
                boundary_scan_pkg::st_cap_ir:   d.st = tms ? boundary_scan_pkg::st_exit1_ir
                                                           : boundary_scan_pkg::st_shift_ir;
                boundary_scan_pkg::st_shift_ir: d.st = tms ? boundary_scan_pkg::st_exit1_ir
                                                           : boundary_scan_pkg::st_shift_ir;
                boundary_scan_pkg::st_exit1_ir: d.st = tms ? boundary_scan_pkg::st_upd_ir
                                                           : boundary_scan_pkg::st_pause_ir;
                boundary_scan_pkg::st_pause_ir: d.st = tms ? boundary_scan_pkg::st_exit2_ir
                                                           : boundary_scan_pkg::st_pause_ir;
                boundary_scan_pkg::st_exit2_ir: d.st = tms ? boundary_scan_pkg::st_upd_ir
                                                           : boundary_scan_pkg::st_shift_ir;
                boundary_scan_pkg::st_upd_ir:   d.st = tms ? boundary_scan_pkg::st_sel_dr
                                                           : boundary_scan_pkg::st_idle;
                default:                        d.st = boundary_scan_pkg::st_reset;
            endcase
        end
    end

    // Test reset acts at once, no clock needed; a stopped clock keeps state
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            q.st <= boundary_scan_pkg::st_reset;
        end else begin
            q <= d;
        end
    end

    assign state = q.st;

    tms_five_a: assert property (@(posedge tck) disable iff (!trst_n)
        tms [*5] |=> q.st == boundary_scan_pkg::st_reset)
        else $error("five high mode selects did not reach reset");
    reset_exit_a: assert property (@(posedge tck) disable iff (!trst_n || force_reset)
        (q.st == boundary_scan_pkg::st_reset && !tms)
        |=> q.st == boundary_scan_pkg::st_idle ##1 1'b1)
        else $error("reset state did not leave to idle");
endmodule
`default_nettype wire

// ==== core/boundary_scan_tap.sv ====
/*
 * Boundary-scan test access port: instruction register, boundary chain,
 * identification and bypass registers, falling-edge data out and pin muxing.
 * Assumes the test clock comes from an external scan master and may stop
 * between scans; sys_clk carries the processor reset and isolation flag.
 */
`include "boundary_scan_defines.svh"
`default_nettype none
module boundary_scan_tap #(
    parameter logic [3:0]  ID_VERSION = 4'h1,   // Arbitrary value
    parameter logic [15:0] ID_PART    = 16'h5a5a, // Arbitrary value
    parameter logic [10:0] ID_MAKER   = 11'h2aa  // Arbitrary value
) (
    // System clock domain
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    output logic                       core_isolated,
    // Scan link
    input  wire logic                  tck,
    input  wire logic                  trst_n,
    input  wire logic                  tms,
    input  wire logic                  tdi,
    output logic                       tdo,
    output logic                       tdo_oe,
    // Pins, indexed by chain position
    input  wire logic [`BSR_LEN-1:0]   core_drive,
    input  wire logic [`BSR_LEN-1:0]   pad_in,
    output logic      [`BSR_LEN-1:0]   pad_drive
);
    localparam int IRW = `IR_WIDTH;
    localparam int BL  = `BSR_LEN;

    // Input-only cells of the chain
    function automatic logic is_input_cell(input int i);
        case (i)
            218, 217, 216, 215, 214, 213, 212, 211, 210, 209, 208, 207,
            176, 173, 162, 139, 128, 123, 118, 117, 108, 103, 90, 79:
                is_input_cell = 1'b1;
            default:
                is_input_cell = 1'b0;
        endcase
    endfunction

    // Enable cells: first of each pair walking down from the top
    function automatic logic [BL-1:0] enable_mask();
        logic [BL-1:0] m;
        logic          pair_hi;
        m       = '0;
        pair_hi = 1'b1;
        for (int i = `BSR_TOP; i > `BSR_RESERVED; i--) begin
            if (is_input_cell(i)) begin
                pair_hi = 1'b1;
            end else if (pair_hi) begin
                m[i]    = 1'b1;
                pair_hi = 1'b0;
            end else begin
                pair_hi = 1'b1;
            end
        end
        return m;
    endfunction

    // Register selected by an instruction code
    function automatic boundary_scan_pkg::reg_sel_t decode_sel(input logic [IRW-1:0] ir);
        case (ir)
            `INSTR_EXTEST, `INSTR_SAMPLE: decode_sel = boundary_scan_pkg::sel_chain;
            `INSTR_IDREAD:                decode_sel = boundary_scan_pkg::sel_ident;
            default:                      decode_sel = boundary_scan_pkg::sel_bypass;
        endcase
    endfunction

    localparam logic [BL-1:0] EN_MASK = enable_mask();

    localparam logic [`ID_WIDTH-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, `ID_LSB_VAL};

    boundary_scan_pkg::tap_state_t st;
    boundary_scan_pkg::reg_sel_t   sel;
    boundary_scan_pkg::scan_q_t    q, d;
    boundary_scan_pkg::out_q_t     oq, od;
    logic                          rst_hold_q;
    logic                          sys_reset_s;
    logic [2*BL-1:0]               pins_s;
    logic [BL-1:0]                 core_s;
    logic [BL-1:0]                 pad_s;
    logic [BL-1:0]                 cap_val;
    logic                          extest_on;
    logic                          float_on;
    logic                          in_shift;

    // Processor reset is held in the system domain, then crosses as a level
    always_ff @(posedge sys_clk) begin
        rst_hold_q <= reset;
    end

    scan_sync #(.WIDTH(1)) u_reset_sync (
        .clk   (tck),
        .clear (1'b0),
        .d     (rst_hold_q),
        .q     (sys_reset_s)
    );

    // Pins are asynchronous to the test clock
    scan_sync #(.WIDTH(2 * BL)) u_pin_sync (
        .clk   (tck),
        .clear (1'b0),
        .d     ({core_drive, pad_in}),
        .q     (pins_s)
    );
    assign core_s = pins_s[2*BL-1:BL];
    assign pad_s  = pins_s[BL-1:0];

    // Tell the core when the scan logic owns the pins
    scan_sync #(.WIDTH(1)) u_iso_sync (
        .clk   (sys_clk),
        .clear (reset),
        .d     (extest_on | float_on),
        .q     (core_isolated)
    );

    tap_fsm u_fsm (
        .tck         (tck),
        .trst_n      (trst_n),
        .tms         (tms),
        .force_reset (sys_reset_s),
        .state       (st)
    );

    assign sel       = decode_sel(q.ir_out);
    assign extest_on = (q.ir_out == `INSTR_EXTEST);
    assign float_on  = (q.ir_out == `INSTR_FLOAT);
    assign in_shift  = (st == boundary_scan_pkg::st_shift_ir) ||
                       (st == boundary_scan_pkg::st_shift_dr);

    // Per-cell capture value and pin drive
    generate
        for (genvar i = 0; i < BL; i++) begin : g_cell
            if (i == `BSR_RESERVED) begin : g_resv
                assign cap_val[i]   = 1'b0;
                assign pad_drive[i] = 1'b0;
            end else if (is_input_cell(i)) begin : g_in
                assign cap_val[i]   = pad_s[i];
                assign pad_drive[i] = 1'b0;
            end else if (EN_MASK[i]) begin : g_en
                // Extest leaves enable cells as shifted, float forces zero
                assign cap_val[i]   = extest_on ? q.bsr_shift[i] : core_s[i];
                assign pad_drive[i] = extest_on ? q.bsr_out[i]
                                    : (float_on ? 1'b0 : core_drive[i]);
            end else begin : g_val
                // A bidirectional value reads as output only when enabled
                assign cap_val[i]   = extest_on ? pad_s[i]
                                    : (core_s[i+1] ? core_s[i] : pad_s[i]);
                assign pad_drive[i] = extest_on ? q.bsr_out[i] : core_drive[i];
            end
        end
    endgenerate

    // Capture, shift and update of all scan registers
    always_comb begin
        d = q;
        case (st)
            boundary_scan_pkg::st_reset: begin
                d.ir_out   = `INSTR_IDREAD;
                d.ir_shift = `INSTR_IDREAD;
            end
            boundary_scan_pkg::st_cap_ir: begin
                d.ir_shift = `IR_CAPTURE_VAL;
            end
            boundary_scan_pkg::st_shift_ir: begin
                d.ir_shift = {tdi, q.ir_shift[IRW-1:1]};
            end
            boundary_scan_pkg::st_upd_ir: begin
                d.ir_out = q.ir_shift;
            end
            boundary_scan_pkg::st_cap_dr: begin
                case (sel)
                    boundary_scan_pkg::sel_chain:  d.bsr_shift = cap_val;
                    boundary_scan_pkg::sel_ident:  d.id_shift  = ID_VALUE;
                    default:                       d.bypass    = 1'b0;
                endcase
            end
            boundary_scan_pkg::st_shift_dr: begin
                case (sel)
                    boundary_scan_pkg::sel_chain:
                        d.bsr_shift = {tdi, q.bsr_shift[BL-1:1]};
                    boundary_scan_pkg::sel_ident:
                        d.id_shift  = {tdi, q.id_shift[`ID_WIDTH-1:1]};
                    default:
                        d.bypass    = tdi;
                endcase
            end
            boundary_scan_pkg::st_upd_dr: begin
                if (sel == boundary_scan_pkg::sel_chain) begin
                    d.bsr_out = q.bsr_shift;
                end
            end
            default: begin
                d = q;
            end
        endcase
    end

    // Rising-edge registers; async test reset; nothing moves without a clock
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            q.ir_shift  <= `INSTR_IDREAD;
            q.ir_out    <= `INSTR_IDREAD;
            q.bsr_shift <= '0;
            q.bsr_out   <= '0;
            q.id_shift  <= '0;
            q.bypass    <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Data out from the low end of the selected register
    always_comb begin
        od = oq;
        od.tdo_oe = in_shift;
        if (st == boundary_scan_pkg::st_shift_ir) begin
            od.tdo = q.ir_shift[0];
        end else if (st == boundary_scan_pkg::st_shift_dr) begin
            case (sel)
                boundary_scan_pkg::sel_chain: od.tdo = q.bsr_shift[`BSR_RESERVED];
                boundary_scan_pkg::sel_ident: od.tdo = q.id_shift[0];
                default:                      od.tdo = q.bypass;
            endcase
        end
    end

    // Falling edge gives the master a full half period of setup
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            oq.tdo    <= 1'b0;
            oq.tdo_oe <= 1'b0;
        end else begin
            oq <= od;
        end
    end

    assign tdo    = oq.tdo;
    assign tdo_oe = oq.tdo_oe;

    // One bypass shift cycle; the bypass check below asks for two in a row
    sequence byp_shift_s;
        st == boundary_scan_pkg::st_shift_dr && sel == boundary_scan_pkg::sel_bypass;
    endsequence

    ir_capture_a: assert property (@(posedge tck) disable iff (!trst_n)
        st == boundary_scan_pkg::st_cap_ir |=> q.ir_shift == `IR_CAPTURE_VAL)
        else $error("capture did not load 00001");
    ir_shift_a: assert property (@(posedge tck) disable iff (!trst_n)
        st == boundary_scan_pkg::st_shift_ir
        |=> q.ir_shift == {$past(tdi), $past(q.ir_shift[IRW-1:1])})
        else $error("instruction shift wrong");
    ir_hold_a: assert property (@(posedge tck) disable iff (!trst_n)
        (st != boundary_scan_pkg::st_upd_ir && st != boundary_scan_pkg::st_reset)
        |=> $stable(q.ir_out))
        else $error("active instruction changed outside update");
    reset_idcode_a: assert property (@(posedge tck) disable iff (!trst_n)
        st == boundary_scan_pkg::st_reset |=> q.ir_out == `INSTR_IDREAD)
        else $error("reset did not load identify instruction");
    chain_shift_a: assert property (@(posedge tck) disable iff (!trst_n)
        (st == boundary_scan_pkg::st_shift_dr && sel == boundary_scan_pkg::sel_chain)
        |=> q.bsr_shift == {$past(tdi), $past(q.bsr_shift[BL-1:1])})
        else $error("boundary shift wrong");
    chain_update_a: assert property (@(posedge tck) disable iff (!trst_n)
        (st == boundary_scan_pkg::st_upd_dr && sel == boundary_scan_pkg::sel_chain)
        |=> q.bsr_out == $past(q.bsr_shift))
        else $error("boundary update missed");
    bypass_path_a: assert property (@(posedge tck) disable iff (!trst_n)
        byp_shift_s ##1 byp_shift_s |-> q.bypass == $past(tdi))
        else $error("bypass is not one bit");
    out_enable_a: assert property (@(posedge tck) disable iff (!trst_n)
        tdo_oe == in_shift)
        else $error("data out driven outside shift");
    float_pins_a: assert property (@(posedge tck) disable iff (!trst_n)
        float_on |-> (pad_drive & EN_MASK) == '0)
        else $error("float instruction left a pin enabled");
    one_select_a: assert property (@(posedge tck) disable iff (!trst_n)
        $onehot(sel))
        else $error("not exactly one data register selected");

    // Capture passed straight on to update, so the captured code becomes active
    sequence ir_cap_s;
        st == boundary_scan_pkg::st_cap_ir;
    endsequence
    sequence ir_skip_shift_s;
        st == boundary_scan_pkg::st_exit1_ir ##1 st == boundary_scan_pkg::st_upd_ir;
    endsequence
    no_shift_sample_a: assert property (@(posedge tck) disable iff (!trst_n)
        ir_cap_s ##1 ir_skip_shift_s |=> q.ir_out == `INSTR_SAMPLE)
        else $error("update after capture did not select sample");
    chain_reserved_a: assert property (@(posedge tck) disable iff (!trst_n)
        (st == boundary_scan_pkg::st_cap_dr && sel == boundary_scan_pkg::sel_chain)
        |=> q.bsr_shift[`BSR_RESERVED] == 1'b0)
        else $error("reserved chain cell took a pin value");
    ident_lsb_a: assert property (@(posedge tck) disable iff (!trst_n)
        (st == boundary_scan_pkg::st_cap_dr && sel == boundary_scan_pkg::sel_ident)
        |=> q.id_shift[0] == `ID_LSB_VAL)
        else $error("identification low bit is not one");
    sys_reset_a: assert property (@(posedge tck) disable iff (!trst_n)
        sys_reset_s |=> st == boundary_scan_pkg::st_reset)
        else $error("processor reset did not reset the controller");
    // Checked without a disable: the test reset itself is the antecedent
    trst_state_a: assert property (@(posedge tck)
        !trst_n |-> st == boundary_scan_pkg::st_reset)
        else $error("test reset did not hold the reset state");
    ir_tdo_a: assert property (@(negedge tck) disable iff (!trst_n)
        st == boundary_scan_pkg::st_shift_ir |=> tdo == $past(q.ir_shift[0]))
        else $error("instruction bit not launched on the falling edge");
    sample_input_a: assert property (@(posedge tck) disable iff (!trst_n)
        (st == boundary_scan_pkg::st_cap_dr && q.ir_out == `INSTR_SAMPLE)
        |=> q.bsr_shift[212] == $past(pad_s[212]))
        else $error("sample capture missed the reset input cell");
    extest_input_a: assert property (@(posedge tck) disable iff (!trst_n)
        (st == boundary_scan_pkg::st_cap_dr && extest_on)
        |=> q.bsr_shift[279] == $past(pad_s[279]))
        else $error("external test capture did not read the pin");
    extest_drive_a: assert property (@(posedge tck) disable iff (!trst_n)
        extest_on |-> pad_drive[`BSR_TOP] == q.bsr_out[`BSR_TOP])
        else $error("external test did not drive from the output stage");
endmodule
`default_nettype wire

// ==== verif/scan_master.sv ====
/* Scan master model: drives test clock, mode select and data in.
   Assumes the device samples on rising tck and launches data out on falling tck. */
`default_nettype none
module scan_master (
    // Link to the device
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clock rests low between frames; data in sits at its pull-up level
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One 160 ns clock; inputs move mid low phase, data out read at the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #40;
        tck = 1'b1;
        o = tdo;
        #80;
        tck = 1'b0;
        #40;
    endtask
    // Idle to shift, n bits low bit first, then update and back to idle
    task automatic scan(input logic ir, input int n, input logic [280:0] din,
                        output logic [280:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b1, o);
        if (ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
/* Bench: scenarios drive the scan link through the master model and
   judge data out, pin drive and isolation. Assumes core sources come first. */
`include "boundary_scan_defines.svh"
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                sys_clk, reset, trst_n, tck, tms, tdi, tdo, tdo_oe, iso, o;
    logic [`BSR_LEN-1:0] core_drive, pad_in, pad_drive, got;
    int                  bad_count, checks_done, cycles;
    localparam logic [31:0] IDV = {4'h1, 16'h5a5a, 11'h2aa, 1'b1};
    boundary_scan_tap u_dut (.sys_clk(sys_clk), .reset(reset), .core_isolated(iso),
        .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .core_drive(core_drive), .pad_in(pad_in), .pad_drive(pad_drive));
    // Released data out line shows the inverse, never a stale level
    scan_master u_master (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo : ~tdo));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard, well above the few thousand cycles the scans need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic to_reset();
        repeat (5) u_master.step(1'b1, 1'b1, o);
        u_master.step(1'b0, 1'b1, o);
    endtask
    task automatic t_bypass();
        logic [4:0] codes [4] = '{5'h1f, 5'h04, 5'h1e, 5'h03};
        foreach (codes[k]) begin
            u_master.scan(1'b1, 5, codes[k], got);
            `CHK(got[4:0], 5'h01)
            `CHK(tdo_oe, 1'b0)
            u_master.scan(1'b0, 2, 2'b01, got);
            `CHK(got[1], 1'b1)
            `CHK(pad_drive[280], codes[k] != 5'h03)
        end
        $display("bypass done");
    endtask
    task automatic t_ident();
        trst_n = 1'b0;
        u_master.step(1'b0, 1'b1, o);
        trst_n = 1'b1;
        u_master.step(1'b0, 1'b1, o);
        u_master.scan(1'b0, 32, '0, got);
        `CHK(got[31:0], IDV)
        u_master.scan(1'b1, 5, 5'h1f, got);
        to_reset();
        u_master.scan(1'b0, 32, '0, got);
        `CHK(got[31:0], IDV)
        $display("ident done");
    endtask
    task automatic t_pins();
        u_master.scan(1'b1, 5, 5'h01, got);
        u_master.scan(1'b0, 281, 281'h3 << 279, got);
        `CHK({got[280:279], got[212], got[139]}, 4'b1011)
        u_master.scan(1'b1, 5, 5'h00, got);
        `CHK(pad_drive[280:279], 2'b11)
        u_master.scan(1'b0, 281, '0, got);
        `CHK({got[279], got[212]}, 2'b11)
        repeat (4) @(posedge sys_clk);
        #5;
        `CHK(iso, 1'b1)
        to_reset();
        repeat (4) @(posedge sys_clk);
        #5;
        `CHK({iso, pad_drive[280]}, 2'b01)
        $display("pins done");
    endtask
    task automatic t_no_shift();
        u_master.step(1'b1, 1'b1, o);
        u_master.step(1'b1, 1'b1, o);
        u_master.step(1'b0, 1'b1, o);
        u_master.step(1'b1, 1'b1, o);
        u_master.step(1'b1, 1'b1, o);
        u_master.step(1'b0, 1'b1, o);
        u_master.scan(1'b0, 2, '0, got);
        `CHK(got[1:0], 2'b10)
        $display("no-shift update done");
    endtask
    initial begin
        reset = 1'b1;
        trst_n = 1'b0;
        core_drive = ~(281'h1 << 279);
        pad_in = '1;
        repeat (8) @(posedge sys_clk);
        #5 reset = 1'b0;
        trst_n = 1'b1;
        to_reset();
        t_bypass();
        t_ident();
        t_pins();
        t_no_shift();
        complete_run();
    end
endmodule
`default_nettype wire
